// ==== src/uhric_pkg.sv ====
// Register map, field layout and reset values of the host receive interval, build options and endpoint 0 port block
package uhric_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] ADDR_EP_SELECT = 8'h00;
	localparam logic [7:0] ADDR_EP_TYPE = 8'h04;
	localparam logic [7:0] ADDR_POLL_INTERVAL = 8'h08;
	localparam logic [7:0] ADDR_BUILD_OPTIONS = 8'h0c;
	localparam logic [7:0] ADDR_EP0_DATA = 8'h10;
	localparam logic [7:0] ADDR_FIFO_LEVELS = 8'h14;

	// Field positions
	localparam int SPEED_LSB = 6;
	localparam int PROTO_LSB = 4;
	localparam int TX_LEVEL_LSB = 16;
	localparam int RX_LEVEL_LSB = 0;

	// Build option bit positions
	localparam int OPT_BULK_RX_COMBINE_BIT = 7;
	localparam int OPT_BULK_TX_SPLIT_BIT = 6;
	localparam int OPT_BYTE_ORDER_BIT = 5;
	localparam int OPT_HIBAND_RX_BIT = 4;
	localparam int OPT_HIBAND_TX_BIT = 3;
	localparam int OPT_RESIZABLE_BIT = 2;
	localparam int OPT_SW_ATTACH_BIT = 1;
	localparam int OPT_PHY_WIDTH_BIT = 0;

	// Values after reset
	localparam logic [7:0] POLL_INTERVAL_RESET = 8'h00;
	localparam logic [3:0] EP_TYPE_RESET = 4'h0;
	localparam logic [7:0] BUILD_OPTIONS_RESET = 8'h06;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;

	// Target speed codes
	localparam logic [1:0] SPEED_ILLEGAL = 2'h0;
	localparam logic [1:0] SPEED_HIGH = 2'h1;
	localparam logic [1:0] SPEED_FULL = 2'h2;
	localparam logic [1:0] SPEED_LOW = 2'h3;

	// Transfer type codes
	localparam logic [1:0] XFER_CONTROL = 2'h0;
	localparam logic [1:0] XFER_ISO = 2'h1;
	localparam logic [1:0] XFER_BULK = 2'h2;
	localparam logic [1:0] XFER_INTR = 2'h3;

	// Interval ranges
	localparam logic [7:0] EXP_MAX = 8'h10;
	localparam logic [7:0] BULK_MIN = 8'h02;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : uhric_pkg

// ==== src/uhric_regs.sv ====
// Host receive interval registers, build option word and endpoint 0 data port behind an AXI4-Lite slave
// Behaviour
// R1 - Eight-bit interval per selected endpoint, reset zero, readable and writable.
// R2 - For bulk endpoints the interval sets the continuous NAK timeout length.
// R3 - Every endpoint except endpoint 0 has an interval register.
// R4 - Low/full speed interrupt: m from 1 to 255 polls every m frames.
// R5 - High speed interrupt: m 1..16 polls every 2^(m-1) microframes.
// R6 - Isochronous: m 1..16 polls every 2^(m-1) frames or microframes.
// R7 - Bulk: m 2..16 gives a NAK limit of 2^(m-1).
// R8 - Interval 0 or 1 disables the bulk NAK timeout.
// R9 - Build option word is read-only; bits 2 and 1 default to one.
// R10 - Bit 7 reports bulk receive packet combining built in.
// R11 - Bit 6 reports bulk transmit packet splitting built in.
// R12 - Bit 5 reports byte order: zero little-endian, one big-endian.
// R13 - Bit 4 reports high-bandwidth receive isochronous support.
// R14 - Bit 3 reports high-bandwidth transmit isochronous support.
// R15 - Bit 2 reports resizable FIFO option present.
// R16 - Bit 1 reports software connect and disconnect option present.
// R17 - Bit 0 reports transceiver path width: zero 8 bits, one 16.
// R18 - Writing the endpoint 0 data port pushes into its transmit FIFO.
// R19 - Reading the endpoint 0 data port pops its receive FIFO.
// R20 - Speed code: 1 high, 2 full, 3 low, 0 illegal.
// R21 - Transfer code: 0 control, 1 isochronous, 2 bulk, 3 interrupt.
// R22 - Software writes the interval only in host mode with endpoint selected; there is no host mode here, any selected endpoint but 0 takes it.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module uhric_regs #(
	parameter int NUM_EP = 5,
	parameter int FIFO_DEPTH = 16,
	parameter bit HAS_BULK_RX_COMBINE = uhric_pkg::BUILD_OPTIONS_RESET[uhric_pkg::OPT_BULK_RX_COMBINE_BIT],
	parameter bit HAS_BULK_TX_SPLIT = uhric_pkg::BUILD_OPTIONS_RESET[uhric_pkg::OPT_BULK_TX_SPLIT_BIT],
	parameter bit BIG_ENDIAN_BUS = uhric_pkg::BUILD_OPTIONS_RESET[uhric_pkg::OPT_BYTE_ORDER_BIT],
	parameter bit HAS_HIBAND_RX = uhric_pkg::BUILD_OPTIONS_RESET[uhric_pkg::OPT_HIBAND_RX_BIT],
	parameter bit HAS_HIBAND_TX = uhric_pkg::BUILD_OPTIONS_RESET[uhric_pkg::OPT_HIBAND_TX_BIT],
	parameter bit HAS_RESIZABLE = uhric_pkg::BUILD_OPTIONS_RESET[uhric_pkg::OPT_RESIZABLE_BIT],
	parameter bit HAS_SW_ATTACH = uhric_pkg::BUILD_OPTIONS_RESET[uhric_pkg::OPT_SW_ATTACH_BIT],
	parameter bit PHY_WIDE = uhric_pkg::BUILD_OPTIONS_RESET[uhric_pkg::OPT_PHY_WIDTH_BIT]
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Endpoint 0 transmit stream towards the USB side
	output logic [31:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	// Endpoint 0 receive stream from the USB side
	input wire logic [31:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	// Scheduler query: endpoint in, timing out
	input wire logic [$clog2(NUM_EP)-1:0] sched_ep,
	output logic [15:0] sched_period,
	output logic sched_valid,
	output logic sched_nak_en
);
	import uhric_pkg::*;

	localparam int EPW = $clog2(NUM_EP);
	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	// Refuse shapes the logic cannot serve, at elaboration
	if (NUM_EP < 2 || NUM_EP > 16)
	begin : g_bad_ep
		$error("NUM_EP must lie in 2..16");
	end
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two in 2..128");
	end

	// Word address match
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr[7:2] == off[7:2]);
	endfunction : hit

	// Interval to {valid, nak timeout enable, period}
	function automatic logic [17:0] timing(input logic [1:0] spd, input logic [1:0] transfer_type_code, input logic [7:0] m);
		logic [15:0] pw;
		logic in16;
		pw = 16'h0001 << 4'(m - 8'h01);
		in16 = (m != 8'h00) && (m <= EXP_MAX);
		timing = {2'b00, 16'h0000};
		if (spd != SPEED_ILLEGAL)
		begin
			// R4 R5 R6 R7 R8 interval decode per type
			unique case (transfer_type_code)
				XFER_INTR:
					if (spd == SPEED_HIGH)
						timing = {in16, 1'b0, in16 ? pw : 16'h0000};
					else
						timing = {m != 8'h00, 1'b0, {8'h00, m}};
				XFER_ISO:
					timing = {in16, 1'b0, in16 ? pw : 16'h0000};
				XFER_BULK:
					if (m >= BULK_MIN && m <= EXP_MAX)
						timing = {2'b11, pw};
				XFER_CONTROL:
					timing = {2'b00, 16'h0000};
			endcase
		end
	endfunction : timing

	// Per endpoint state
	logic [7:0] interval_mem [NUM_EP];
	logic [3:0] type_mem [NUM_EP];
	logic [EPW-1:0] ep_sel_reg;

	// FIFO state
	logic [31:0] txq [FIFO_DEPTH];
	logic [31:0] rxq [FIFO_DEPTH];
	logic [PW-1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
	logic [CW-1:0] tx_cnt_reg, rx_cnt_reg;

	// Bus state
	logic aw_have_reg, w_have_reg;
	logic [7:0] aw_addr_reg, rd_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic tx_valid_reg, rx_ready_reg;
	logic [31:0] tx_data_reg;
	logic [15:0] sched_period_reg;
	logic sched_valid_reg, sched_nak_en_reg;

	// Build option word assembled from build-time choices
	wire [7:0] build_word;
	// R10 combine flag
	assign build_word[OPT_BULK_RX_COMBINE_BIT] = HAS_BULK_RX_COMBINE;
	// R11 split flag
	assign build_word[OPT_BULK_TX_SPLIT_BIT] = HAS_BULK_TX_SPLIT;
	// R12 byte order
	assign build_word[OPT_BYTE_ORDER_BIT] = BIG_ENDIAN_BUS;
	// R13 hiband receive
	assign build_word[OPT_HIBAND_RX_BIT] = HAS_HIBAND_RX;
	// R14 hiband transmit
	assign build_word[OPT_HIBAND_TX_BIT] = HAS_HIBAND_TX;
	// R15 resizable buffers
	assign build_word[OPT_RESIZABLE_BIT] = HAS_RESIZABLE;
	// R16 software attach
	assign build_word[OPT_SW_ATTACH_BIT] = HAS_SW_ATTACH;
	// R17 path width
	assign build_word[OPT_PHY_WIDTH_BIT] = PHY_WIDE;

	// Write channel decode
	wire aw_fire = awvalid && awready_reg;
	wire w_fire = wvalid && wready_reg;
	wire wr_do = aw_have_reg && w_have_reg && !bvalid_reg;
	wire wr_sel = wr_do && hit(aw_addr_reg, ADDR_EP_SELECT);
	wire wr_type = wr_do && hit(aw_addr_reg, ADDR_EP_TYPE);
	wire wr_intv = wr_do && hit(aw_addr_reg, ADDR_POLL_INTERVAL);
	wire wr_data = wr_do && hit(aw_addr_reg, ADDR_EP0_DATA);
	wire wr_ro = wr_do && (hit(aw_addr_reg, ADDR_BUILD_OPTIONS) || hit(aw_addr_reg, ADDR_FIFO_LEVELS));
	wire sel_ok = 32'(w_data_reg[EPW-1:0]) < NUM_EP && w_data_reg[7:EPW] == '0;
	wire tx_push = wr_data && (32'(tx_cnt_reg) < FIFO_DEPTH);
	wire wr_err = (wr_sel && !sel_ok) || (wr_data && !tx_push) || wr_ro;
	wire wr_ok = wr_sel || wr_type || wr_intv || wr_data || wr_ro;
	wire aw_have_next = (aw_have_reg && !wr_do) || aw_fire;
	wire w_have_next = (w_have_reg && !wr_do) || w_fire;
	wire bvalid_next = wr_do || (bvalid_reg && !bready);

	// Read channel decode
	wire ar_fire = arvalid && arready_reg;
	wire rd_data = ar_fire && hit(araddr, ADDR_EP0_DATA);
	wire rx_pop = rd_data && (rx_cnt_reg != '0);
	wire rvalid_next = ar_fire || (rvalid_reg && !rready);
	// R3 endpoint 0 interval reads zero
	wire [7:0] sel_interval = (ep_sel_reg == '0) ? 8'h00 : interval_mem[ep_sel_reg];
	wire [31:0] levels_word = (32'(tx_cnt_reg) << TX_LEVEL_LSB) | (32'(rx_cnt_reg) << RX_LEVEL_LSB);
	wire rd_known = hit(araddr, ADDR_EP_SELECT) || hit(araddr, ADDR_EP_TYPE) || hit(araddr, ADDR_POLL_INTERVAL)
		|| hit(araddr, ADDR_BUILD_OPTIONS) || hit(araddr, ADDR_EP0_DATA) || hit(araddr, ADDR_FIFO_LEVELS);
	// R9 read-only build word
	wire [31:0] rd_word = hit(araddr, ADDR_EP_SELECT) ? 32'(ep_sel_reg)
		: hit(araddr, ADDR_EP_TYPE) ? {24'h0, type_mem[ep_sel_reg], 4'h0}
		: hit(araddr, ADDR_POLL_INTERVAL) ? {24'h0, sel_interval}
		: hit(araddr, ADDR_BUILD_OPTIONS) ? {24'h0, build_word}
		: rx_pop ? rxq[rx_rp_reg]
		: hit(araddr, ADDR_FIFO_LEVELS) ? levels_word
		: 32'h0;

	// FIFO handshakes towards the USB side
	wire tx_load = (tx_cnt_reg != '0) && (!tx_valid_reg || tx_ready);
	wire rx_push = rx_valid && rx_ready_reg;
	wire [CW-1:0] tx_cnt_next = tx_cnt_reg + CW'(tx_push) - CW'(tx_load);
	wire [CW-1:0] rx_cnt_next = rx_cnt_reg + CW'(rx_push) - CW'(rx_pop);

	// Scheduler lookup for the queried endpoint
	// Endpoints beyond the configured count read as unconfigured, never as unknown
	wire sched_ep_ok = 32'(sched_ep) < NUM_EP;
	wire [7:0] sched_m = (sched_ep == '0 || !sched_ep_ok) ? 8'h00 : interval_mem[sched_ep];
	wire [3:0] sched_type = sched_ep_ok ? type_mem[sched_ep] : EP_TYPE_RESET;
	wire [1:0] sched_spd = sched_type[SPEED_LSB-4 +: 2];
	wire [1:0] sched_transfer_type_code = sched_type[PROTO_LSB-4 +: 2];
	// R2 bulk timeout from interval
	wire [17:0] sched_calc = timing(sched_spd, sched_transfer_type_code, sched_m);

	// Write side handshake state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end
		else
		begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awready_reg <= !aw_have_next && !bvalid_next;
			wready_reg <= !w_have_next && !bvalid_next;
			bvalid_reg <= bvalid_next;
			if (wr_do)
				bresp_reg <= (wr_err || !wr_ok) ? RESP_SLVERR : RESP_OKAY;
		end
	end

	// Write payload capture
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_addr_reg <= 8'h00;
			w_data_reg <= DATA_RESET;
			w_strb_reg <= 4'h0;
		end
		else
		begin
			if (aw_fire)
				aw_addr_reg <= awaddr;
			if (w_fire)
			begin
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
		end
	end

	// Endpoint select and per endpoint registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ep_sel_reg <= '0;
			for (int i = 0; i < NUM_EP; i++)
			begin
				interval_mem[i] <= POLL_INTERVAL_RESET;
				type_mem[i] <= EP_TYPE_RESET;
			end
		end
		else
		begin
			if (wr_sel && sel_ok && w_strb_reg[0])
				ep_sel_reg <= w_data_reg[EPW-1:0];
			// R20 speed and R21 transfer codes stored
			if (wr_type && w_strb_reg[0])
				type_mem[ep_sel_reg] <= w_data_reg[7:4];
			// R1 interval store, R3 none for endpoint 0
			if (wr_intv && w_strb_reg[0] && ep_sel_reg != '0)
				interval_mem[ep_sel_reg] <= w_data_reg[7:0];
		end
	end

	// Read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= DATA_RESET;
			rresp_reg <= RESP_OKAY;
			rd_addr_reg <= 8'h00;
		end
		else
		begin
			arready_reg <= !rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_fire)
			begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
				rd_addr_reg <= araddr;
			end
		end
	end

	// Transmit FIFO storage and output stage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_wp_reg <= '0;
			tx_rp_reg <= '0;
			tx_cnt_reg <= '0;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= DATA_RESET;
		end
		else
		begin
			// R18 push on data port write
			if (tx_push)
			begin
				txq[tx_wp_reg] <= w_data_reg;
				tx_wp_reg <= tx_wp_reg + 1'b1;
			end
			if (tx_load)
			begin
				tx_data_reg <= txq[tx_rp_reg];
				tx_rp_reg <= tx_rp_reg + 1'b1;
			end
			tx_cnt_reg <= tx_cnt_next;
			if (tx_load)
				tx_valid_reg <= 1'b1;
			else if (tx_ready)
				tx_valid_reg <= 1'b0;
		end
	end

	// Receive FIFO storage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_wp_reg <= '0;
			rx_rp_reg <= '0;
			rx_cnt_reg <= '0;
			rx_ready_reg <= 1'b0;
		end
		else
		begin
			if (rx_push)
			begin
				rxq[rx_wp_reg] <= rx_data;
				rx_wp_reg <= rx_wp_reg + 1'b1;
			end
			// R19 pop on data port read
			if (rx_pop)
				rx_rp_reg <= rx_rp_reg + 1'b1;
			rx_cnt_reg <= rx_cnt_next;
			rx_ready_reg <= 32'(rx_cnt_next) < FIFO_DEPTH;
		end
	end

	// Scheduler timing outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sched_valid_reg <= 1'b0;
			sched_nak_en_reg <= 1'b0;
			sched_period_reg <= 16'h0000;
		end
		else
		begin
			sched_valid_reg <= sched_calc[17];
			sched_nak_en_reg <= sched_calc[16];
			sched_period_reg <= sched_calc[15:0];
		end
	end

	// Port drive
	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign tx_valid = tx_valid_reg;
	assign tx_data = tx_data_reg;
	assign rx_ready = rx_ready_reg;
	assign sched_valid = sched_valid_reg;
	assign sched_nak_en = sched_nak_en_reg;
	assign sched_period = sched_period_reg;

	// Checks on stored values and derived timing
	a_interval_store: assert property (@(posedge aclk) disable iff (!aresetn) // R1
		(wr_intv && w_strb_reg[0] && ep_sel_reg != '0) |=> interval_mem[$past(ep_sel_reg)] == $past(w_data_reg[7:0]))
		else $error("Interval write not stored");
	a_ep0_no_interval: assert property (@(posedge aclk) disable iff (!aresetn) // R3
		(ar_fire && hit(araddr, ADDR_POLL_INTERVAL) && ep_sel_reg == '0) |=> rdata_reg == 32'h0)
		else $error("Endpoint 0 interval not zero");
	a_intr_low_period: assert property (@(posedge aclk) disable iff (!aresetn) // R4
		(sched_transfer_type_code == XFER_INTR && (sched_spd == SPEED_FULL || sched_spd == SPEED_LOW) && sched_m != 8'h00)
		|=> sched_valid_reg && sched_period_reg == {8'h00, $past(sched_m)})
		else $error("Interrupt frame period wrong");
	a_intr_high_period: assert property (@(posedge aclk) disable iff (!aresetn) // R5
		(sched_transfer_type_code == XFER_INTR && sched_spd == SPEED_HIGH && sched_m >= 8'h01 && sched_m <= 8'h10)
		|=> sched_valid_reg && sched_period_reg == (16'h0001 << ($past(sched_m) - 8'h01)))
		else $error("High speed interrupt period wrong");
	a_iso_period: assert property (@(posedge aclk) disable iff (!aresetn) // R6
		(sched_transfer_type_code == XFER_ISO && sched_spd != SPEED_ILLEGAL && sched_m > 8'h10)
		|=> !sched_valid_reg && sched_period_reg == 16'h0000)
		else $error("Isochronous out of range accepted");
	a_bulk_nak_limit: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		(sched_transfer_type_code == XFER_BULK && sched_spd != SPEED_ILLEGAL && sched_m >= 8'h02 && sched_m <= 8'h10)
		|=> sched_nak_en_reg && sched_period_reg == (16'h0001 << ($past(sched_m) - 8'h01)))
		else $error("Bulk NAK limit wrong");
	a_bulk_nak_off: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		(sched_transfer_type_code == XFER_BULK && sched_m <= 8'h01) |=> !sched_nak_en_reg)
		else $error("NAK timeout not disabled");
	a_build_word_read: assert property (@(posedge aclk) disable iff (!aresetn) // R9
		(rvalid_reg && hit(rd_addr_reg, ADDR_BUILD_OPTIONS)) |-> rdata_reg == {24'h0, build_word})
		else $error("Build option word altered");
	a_tx_push_count: assert property (@(posedge aclk) disable iff (!aresetn) // R18
		(tx_push && !tx_load) |=> tx_cnt_reg == $past(tx_cnt_reg) + 1'b1)
		else $error("Data port write not pushed");
	a_rx_pop_count: assert property (@(posedge aclk) disable iff (!aresetn) // R19
		(rx_pop && !rx_push) |=> rx_cnt_reg == $past(rx_cnt_reg) - 1'b1 && rdata_reg == $past(rxq[rx_rp_reg]))
		else $error("Data port read not popped");
	a_speed_illegal: assert property (@(posedge aclk) disable iff (!aresetn) // R20
		(sched_spd == SPEED_ILLEGAL) |=> !sched_valid_reg && !sched_nak_en_reg)
		else $error("Illegal speed accepted");

endmodule : uhric_regs

// ==== tb/tb_top.sv ====
// Self-checking bench for the host receive interval, build options and endpoint 0 port block
`timescale 1ns/1ps
module tb_top;
	import uhric_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [2:0] sched_ep = 3'h0;
	logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready, rx_valid, rx_ready;
	logic sched_valid, sched_nak_en;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, tx_data, rx_data, w;
	logic [15:0] sched_period;
	logic [33:0] exp_r[$];
	logic [1:0] exp_b[$];
	logic [31:0] exp_tx[$];
	logic [7:0] iv[5];
	logic [7:0] mv[7] = '{8'h00, 8'h01, 8'h02, 8'h09, 8'h10, 8'h11, 8'hff};
	logic [31:0] rw[4];
	int seed = 32'h100faa9b;
	int error_cnt = 0;
	int compares = 0;

	// Clock at 10 MHz
	always #50 aclk = ~aclk;

	// Block under test and its USB-side partner
	uhric_regs dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .sched_ep(sched_ep),
		.sched_period(sched_period), .sched_valid(sched_valid), .sched_nak_en(sched_nak_en));
	uhric_usb_model usb_u (.aclk(aclk), .aresetn(aresetn), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	// Write one word, note the expected response, hold each channel until taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		exp_b.push_back(er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (!aw_ok && awready)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid)
			@(posedge aclk);
		bready <= 1'b0;
	endtask : axi_write

	// Read one word and note the expected response and data
	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		exp_r.push_back({er, ed});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (!arready)
			@(posedge aclk);
		arvalid <= 1'b0;
		while (!rvalid)
			@(posedge aclk);
		rready <= 1'b0;
	endtask : axi_read

	// Expected scheduler timing as {valid, nak_en, period}
	function automatic logic [17:0] sched_exp(input logic [1:0] sp, input logic [1:0] ty, input logic [7:0] m);
		logic sp_ok;
		logic [15:0] p2;
		sp_ok = (sp != SPEED_ILLEGAL);
		p2 = 16'h0001 << (m - 8'h01);
		sched_exp = 18'h00000;
		if (ty == XFER_INTR && (sp == SPEED_FULL || sp == SPEED_LOW) && m != 8'h00)
			sched_exp = {10'h200, m};
		else if (ty == XFER_INTR && sp == SPEED_HIGH && m != 8'h00 && m <= 8'h10)
			sched_exp = {2'b10, p2};
		else if (ty == XFER_ISO && sp_ok && m != 8'h00 && m <= 8'h10)
			sched_exp = {2'b10, p2};
		else if (ty == XFER_BULK && sp_ok && m >= 8'h02 && m <= 8'h10)
			sched_exp = {2'b11, p2};
	endfunction : sched_exp

	// interval written only while its endpoint is selected
	task automatic sched_case(input logic [1:0] sp, input logic [1:0] ty, input logic [7:0] m);
		axi_write(ADDR_EP_TYPE, {24'h000000, sp, ty, 4'h0}, RESP_OKAY);
		axi_write(ADDR_POLL_INTERVAL, {24'h000000, m}, RESP_OKAY);
		@(posedge aclk);
		#1;
		check({16'h0000, sched_valid, sched_nak_en, sched_period}, {16'h0000, sched_exp(sp, ty, m)});
	endtask : sched_case

	// Compare each response against the oldest note
	always @(posedge aclk)
	begin
		if (aresetn && bvalid && bready)
			check({32'h00000000, bresp}, {32'h00000000, exp_b.pop_front()});
		if (aresetn && rvalid && rready)
			check({rresp, rdata}, exp_r.pop_front());
		if (aresetn && tx_valid && tx_ready)
			check({2'h0, tx_data}, {2'h0, exp_tx.pop_front()});
	end

	// Main sequence
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(ADDR_POLL_INTERVAL, 32'h0000_0000, RESP_OKAY);
		axi_read(ADDR_BUILD_OPTIONS, 32'h0000_0006, RESP_OKAY);
		axi_write(ADDR_BUILD_OPTIONS, 32'h0000_00ff, RESP_SLVERR);
		axi_read(ADDR_BUILD_OPTIONS, 32'h0000_0006, RESP_OKAY);
		axi_write(8'h20, 32'h0000_0001, RESP_SLVERR);
		axi_read(8'h20, 32'h0000_0000, RESP_SLVERR);
		axi_write(ADDR_EP_SELECT, 32'h0000_0005, RESP_SLVERR);
		$display("test reset_and_map done");
		for (int e = 0; e < 5; e++)
		begin
			iv[e] = 8'($random(seed));
			axi_write(ADDR_EP_SELECT, 32'(e), RESP_OKAY);
			axi_write(ADDR_POLL_INTERVAL, {24'h000000, iv[e]}, RESP_OKAY);
		end
		iv[0] = 8'h00;
		for (int e = 4; e >= 0; e--)
		begin
			axi_write(ADDR_EP_SELECT, 32'(e), RESP_OKAY);
			axi_read(ADDR_POLL_INTERVAL, {24'h000000, iv[e]}, RESP_OKAY);
		end
		$display("test interval_store done");
		axi_write(ADDR_EP_SELECT, 32'h0000_0002, RESP_OKAY);
		sched_ep <= 3'h2;
		mv[3] = 8'($random(seed));
		for (int s = 0; s < 4; s++)
			for (int t = 0; t < 4; t++)
				for (int k = 0; k < 7; k++)
					sched_case(2'(s), 2'(t), mv[k]);
		axi_read(ADDR_EP_TYPE, 32'h0000_00f0, RESP_OKAY);
		axi_read(ADDR_EP_SELECT, 32'h0000_0002, RESP_OKAY);
		$display("test sched_timing done");
		// transmit pushes in order under stall
		slow <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			w = $random(seed);
			exp_tx.push_back(w);
			axi_write(ADDR_EP0_DATA, w, RESP_OKAY);
		end
		slow <= 1'b0;
		while (exp_tx.size() > 0)
			@(posedge aclk);
		$display("test tx_port done");
		// each of the first four reads pops one received word, the fifth finds the FIFO empty
		for (int i = 0; i < 4; i++)
		begin
			rw[i] = $random(seed);
			usb_u.send(rw[i]);
		end
		while (usb_u.rx_q.size() > 0)
			@(posedge aclk);
		repeat (2) @(posedge aclk);
		axi_read(ADDR_FIFO_LEVELS, 32'h0000_0004, RESP_OKAY);
		axi_write(ADDR_FIFO_LEVELS, 32'h0000_0000, RESP_SLVERR);
		for (int i = 0; i < 4; i++)
			axi_read(ADDR_EP0_DATA, rw[i], RESP_OKAY);
		axi_read(ADDR_EP0_DATA, 32'h0000_0000, RESP_OKAY);
		axi_read(ADDR_FIFO_LEVELS, 32'h0000_0000, RESP_OKAY);
		$display("test rx_port done");
		repeat (3) @(posedge aclk);
		report_and_stop();
	end

	// Cut a hang short
	initial
	begin
		#3_000_000;
		error_cnt++;
		$display("wrong value at %0t: run timed out", $time);
		report_and_stop();
	end
endmodule : tb_top

// ==== tb/uhric_usb_model.sv ====
// Behavioural USB-side partner: drains the endpoint 0 transmit stream and feeds its receive stream
`timescale 1ns/1ps
module uhric_usb_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Stall control from the bench
	input wire logic slow,
	// Transmit stream from the block
	input wire logic [31:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// Receive stream into the block
	output logic [31:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready
);
	logic [31:0] rx_q[$];
	int seed = 32'h100faa9b;
	int r;

	// Queue one word for delivery
	task automatic send(input logic [31:0] w);
		rx_q.push_back(w);
	endtask : send

	// Quiet outputs at time zero
	initial
	begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 32'h0000_0000;
	end

	// Ready is low in reset, random while stalling, otherwise always high
	always @(posedge aclk)
	begin
		r = $random(seed);
		tx_ready <= aresetn && (!slow || r[0]);
	end

	// Offer the oldest word; an idle line toggles so stale data never looks valid
	always @(posedge aclk)
	begin
		if (rx_valid && rx_ready)
			rx_q.delete(0);
		rx_valid <= aresetn && rx_q.size() > 0;
		rx_data <= (rx_q.size() > 0) ? rx_q[0] : ~rx_data;
	end
endmodule : uhric_usb_model
